// >>> verilog/wsc_core.sv
// Watchdog, core interrupt flags and power-down control of a small 8-bit CPU.
// Assumes the CPU core issues instruction pulses and a register port on CLK.
// Operation
// - Timer roll-over from FFh to 00h sets the timer overflow flag.
// - Overflow flag sets regardless of enable; only software clears it.
// - Edge select picks rising (one) or falling (zero) external edges.
// - A selected edge sets the edge flag regardless of its enable; the enable gates the request and the wake from sleep.
// - The edge flag may set anywhere in the Q4-Q1 phases.
// - An enabled edge interrupt wakes from sleep; global enable picks vectoring.
// - Change on port pins 3, 1, 0 sets the port-change flag.
// - Taking an interrupt pushes only the return program counter.
// - The watchdog counts its own free-running RC oscillator.
// - Timeout in normal operation resets the device.
// - Timeout in power-down wakes the device instead.
// - Configuration watchdog enable cleared disables the watchdog permanently.
// - Without prescaler the nominal timeout is 18 ms.
// - Prescaler may be assigned to the watchdog, ratios up to 1:128.
// - Clear-watchdog and sleep instructions clear count and assigned prescaler.
// - A watchdog timeout clears the active-low timeout status bit.
// - Sleep clears power-down bit, sets timeout bit, stops the oscillator driver.
// - Entering sleep clears the watchdog count, which keeps counting.
// - During power-down all pins keep their previous drive state.
// - Global enable allows unmasked interrupts when set, blocks all when clear.
// - Accepting an interrupt clears global enable, pushes PC, loads 0004h.
//
// The plain strobed port was chosen for this implementation.
module wsc_core #(
  parameter int WDT_BASE = wsc_pkg::WDT_BASE_TICKS
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic [13:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic [7:0]  CFG_WORD,
  input  wire logic        WDT_OSC,
  input  wire logic        EXT_IRQ_PIN,
  input  wire logic [3:0]  PORT_PIN,
  input  wire logic        TMR_TICK,
  input  wire logic        CLR_WDT_INSTR,
  input  wire logic        SLEEP_INSTR,
  input  wire logic        RETFIE_INSTR,
  input  wire logic        IRQ_ACK,
  input  wire logic [12:0] RET_PC,
  output logic             IRQ_REQ,
  output logic             PUSH_STB,
  output logic      [12:0] PUSH_PC,
  output logic             VEC_LOAD,
  output logic      [12:0] VEC_PC,
  output logic             WAKE,
  output logic             WAKE_VECTOR,
  output logic             WDT_RESET,
  output logic             SLEEPING,
  output logic             OSC_DRV_EN,
  output logic             IO_HOLD
);
  localparam int WDT_CNT_W = wsc_pkg::WDT_CNT_W;
  // Synchronised pins: bit 4 watchdog osc, 3 external, 2..0 port pins 3,1,0.
  logic [4:0] raw;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] lvl_r;
  wire logic [4:0] lvl_nxt;
  logic [7:0] ctl_r;
  logic [7:0] opt_r;
  logic [7:0] tmr_r;
  logic [7:0] cfg_r;
  logic       cfg_ld_r;
  logic       to_n_r;
  logic       pd_n_r;
  logic [6:0] psc_r;
  logic [WDT_CNT_W-1:0] wdt_r;
  wsc_pkg::wsc_mode_t mode_r;
  logic       tmr_wrap;
  logic       edge_hit;
  logic       port_hit;
  logic       osc_tick;
  logic       psc_hit;
  logic       wdt_step;
  logic       wdt_to;
  logic       wdt_on;
  logic       pend;
  logic       sleep_go;
  logic       wake_go;
  logic       wdt_clr;
  logic [6:0] psc_mask;

  assign raw = {WDT_OSC, EXT_IRQ_PIN, PORT_PIN[3], PORT_PIN[1], PORT_PIN[0]};

  // A change is taken only when the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : g_sync
      always_ff @(posedge CLK)
      begin
        if (!RST_N)
        begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          lvl_r[g] <= 1'b0;
        end
        else if (CE)
        begin
          s1_r[g]  <= raw[g];
          s2_r[g]  <= s1_r[g];
          s3_r[g]  <= s2_r[g];
          lvl_r[g] <= lvl_nxt[g];
        end
      end
      assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
    end
  endgenerate

  // The filtered level of the first sample after reset is trusted only
  // once it has settled, so a pin held high at reset gives a single edge.
  assign osc_tick = lvl_nxt[4] & ~lvl_r[4];
  assign edge_hit = opt_r[wsc_pkg::B_EDGE] ? (lvl_nxt[3] & ~lvl_r[3])
                                           : (~lvl_nxt[3] & lvl_r[3]);
  assign port_hit = |(lvl_nxt[2:0] ^ lvl_r[2:0]);
  assign tmr_wrap = TMR_TICK & (tmr_r == 8'hFF);

  // Configuration is a strap caught after reset; it never changes later.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cfg_r    <= 8'h00;
      cfg_ld_r <= 1'b0;
    end
    else if (CE && !cfg_ld_r)
    begin
      cfg_r    <= CFG_WORD;
      cfg_ld_r <= 1'b1;
    end
  end
  assign wdt_on = cfg_ld_r & cfg_r[wsc_pkg::B_WATCHDOG_ENABLE_CFG];

  // Pending means some source has both its flag and its enable set.
  assign pend = (ctl_r[wsc_pkg::B_TOF] & ctl_r[wsc_pkg::B_TOE])
              | (ctl_r[wsc_pkg::B_EDF] & ctl_r[wsc_pkg::B_EDE])
              | (ctl_r[wsc_pkg::B_PCF] & ctl_r[wsc_pkg::B_PCE]);
  assign IRQ_REQ = pend & ctl_r[wsc_pkg::B_GIE] & (mode_r == wsc_pkg::ST_RUN);

  // A sleep with an interrupt already pending completes as a no-operation.
  assign sleep_go = SLEEP_INSTR & ~pend & (mode_r == wsc_pkg::ST_RUN);
  assign wake_go  = (mode_r == wsc_pkg::ST_SLEEP) & (pend | wdt_to);
  assign wdt_clr  = CLR_WDT_INSTR | sleep_go;

  // Prescaler ratio is 2 to the rate field, so rate 7 gives 1:128.
  assign psc_mask = 7'(8'h01 << opt_r[wsc_pkg::B_PS_LSB +: 3]) - 7'h01;
  assign psc_hit  = (psc_r & psc_mask) == psc_mask;
  assign wdt_step = osc_tick & (~opt_r[wsc_pkg::B_PSA] | psc_hit);
  assign wdt_to   = wdt_on & wdt_step & (32'(wdt_r) == WDT_BASE - 1);

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      psc_r <= 7'h00;
    else if (CE)
    begin
      if (wdt_clr && opt_r[wsc_pkg::B_PSA])
        psc_r <= 7'h00;
      else if (osc_tick && opt_r[wsc_pkg::B_PSA])
        psc_r <= psc_hit ? 7'h00 : psc_r + 7'h01;
    end
  end

  // The count keeps running through sleep; only a clear or timeout restarts it.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      wdt_r <= '0;
    else if (CE)
    begin
      if (wdt_clr || !wdt_on || wdt_to)
        wdt_r <= '0;
      else if (wdt_step)
        wdt_r <= wdt_r + 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      tmr_r <= wsc_pkg::RST_TIMER;
    else if (CE)
    begin
      if (WR && ADDR == wsc_pkg::ADR_TIMER)
        tmr_r <= WDATA;
      else if (TMR_TICK)
        tmr_r <= tmr_r + 8'h01;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      opt_r <= wsc_pkg::RST_OPTION;
    else if (CE && WR && ADDR == wsc_pkg::ADR_OPTION)
      opt_r <= WDATA;
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ctl_r <= wsc_pkg::RST_IRQCTL;
    else if (CE)
    begin
      if (WR && ADDR == wsc_pkg::ADR_IRQCTL)
        ctl_r <= WDATA & 8'hBF;
      if (RETFIE_INSTR)
        ctl_r[wsc_pkg::B_GIE] <= 1'b1;
      if (IRQ_REQ && IRQ_ACK)
        ctl_r[wsc_pkg::B_GIE] <= 1'b0;
      if (tmr_wrap)
        ctl_r[wsc_pkg::B_TOF] <= 1'b1;
      if (edge_hit)
        ctl_r[wsc_pkg::B_EDF] <= 1'b1;
      if (port_hit)
        ctl_r[wsc_pkg::B_PCF] <= 1'b1;
    end
  end

  // Status bits are not writable; they tell software why it woke or restarted.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;
    end
    else if (CE)
    begin
      if (wdt_to)
        to_n_r <= 1'b0;
      else if (sleep_go || CLR_WDT_INSTR)
        to_n_r <= 1'b1;
      if (sleep_go)
        pd_n_r <= 1'b0;
      else if (CLR_WDT_INSTR)
        pd_n_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      mode_r <= wsc_pkg::ST_RUN;
    else if (CE)
    begin
      case (mode_r)
        wsc_pkg::ST_RUN:   if (sleep_go) mode_r <= wsc_pkg::ST_SLEEP;
        wsc_pkg::ST_SLEEP: if (wake_go) mode_r <= wsc_pkg::ST_RUN;
        default:           mode_r <= wsc_pkg::ST_RUN;
      endcase
    end
  end

  // Event outputs are one-cycle pulses from flip-flops.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      WAKE        <= 1'b0;
      WAKE_VECTOR <= 1'b0;
      WDT_RESET   <= 1'b0;
      PUSH_STB    <= 1'b0;
      VEC_LOAD    <= 1'b0;
      PUSH_PC     <= 13'h0000;
    end
    else if (CE)
    begin
      WAKE        <= wake_go;
      WAKE_VECTOR <= wake_go & pend & ctl_r[wsc_pkg::B_GIE];
      WDT_RESET   <= wdt_to & (mode_r == wsc_pkg::ST_RUN);
      PUSH_STB    <= IRQ_REQ & IRQ_ACK;
      VEC_LOAD    <= IRQ_REQ & IRQ_ACK;
      if (IRQ_REQ && IRQ_ACK)
        PUSH_PC <= RET_PC;
    end
  end
  assign VEC_PC     = wsc_pkg::IRQ_VECTOR;
  assign SLEEPING   = mode_r == wsc_pkg::ST_SLEEP;
  assign OSC_DRV_EN = ~SLEEPING;
  assign IO_HOLD    = SLEEPING;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      RDATA <= 8'h00;
    else if (CE)
    begin
      if (!RD)
        RDATA <= 8'h00;
      else
        case (ADDR)
          wsc_pkg::ADR_TIMER:  RDATA <= tmr_r;
          wsc_pkg::ADR_STATUS: RDATA <= 8'({to_n_r, pd_n_r}) << wsc_pkg::B_PD_N;
          wsc_pkg::ADR_IRQCTL: RDATA <= ctl_r;
          wsc_pkg::ADR_OPTION: RDATA <= opt_r;
          wsc_pkg::ADR_CONFIG: RDATA <= cfg_r;
          default:             RDATA <= 8'h00;
        endcase
    end
  end

  // Checks.
  chk_req_needs_all: assert property (@(posedge CLK) disable iff (!RST_N)
    IRQ_REQ |-> ctl_r[wsc_pkg::B_GIE] && pend) else $error("request without enables");
  chk_ovf_sets_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && tmr_wrap |=> ctl_r[wsc_pkg::B_TOF]) else $error("overflow flag not set");
  chk_edge_sets_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && edge_hit |=> ctl_r[wsc_pkg::B_EDF]) else $error("edge flag not set");
  chk_port_sets_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && port_hit |=> ctl_r[wsc_pkg::B_PCF]) else $error("port flag not set");
  chk_accept_clears_gie: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && IRQ_REQ && IRQ_ACK && !RETFIE_INSTR |=> !ctl_r[wsc_pkg::B_GIE] && VEC_LOAD && PUSH_PC == $past(RET_PC))
    else $error("accept did not vector");
  chk_run_timeout_rst: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && wdt_to && !SLEEPING |=> WDT_RESET && !to_n_r) else $error("no watchdog reset");
  chk_sleep_timeout_wk: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && wdt_to && SLEEPING |=> WAKE && !WDT_RESET && !SLEEPING) else $error("no watchdog wake");
  chk_sleep_status: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && sleep_go |=> !pd_n_r && SLEEPING && !OSC_DRV_EN && wdt_r == '0) else $error("sleep entry wrong");
  chk_wdt_disabled: assert property (@(posedge CLK) disable iff (!RST_N)
    cfg_ld_r && !cfg_r[wsc_pkg::B_WATCHDOG_ENABLE_CFG] |-> !wdt_to && wdt_r == '0) else $error("disabled watchdog ran");
  chk_clr_zeroes_wdt: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && CLR_WDT_INSTR |=> wdt_r == '0 && (!opt_r[wsc_pkg::B_PSA] || psc_r == 7'h00))
    else $error("clear missed count");
  cov_sleep_wake: cover property (@(posedge CLK) disable iff (!RST_N) sleep_go ##[1:50] WAKE);
  cov_irq_taken: cover property (@(posedge CLK) disable iff (!RST_N) IRQ_REQ && IRQ_ACK);
  cov_wdt_reset: cover property (@(posedge CLK) disable iff (!RST_N) WDT_RESET);
endmodule : wsc_core

// >>> verilog/wsc_pkg.sv
// Constants of the watchdog, interrupt and power-down block.
// Assumes one main clock domain; all users write wsc_pkg::name.
package wsc_pkg;
  // Register addresses.
  localparam logic [13:0] ADR_TIMER  = 14'h0001;
  localparam logic [13:0] ADR_STATUS = 14'h0003;
  localparam logic [13:0] ADR_IRQCTL = 14'h000B;
  localparam logic [13:0] ADR_OPTION = 14'h0081;
  localparam logic [13:0] ADR_CONFIG = 14'h2007;
  // Interrupt control fields.
  localparam int B_PCF  = 0;
  localparam int B_EDF  = 1;
  localparam int B_TOF  = 2;
  localparam int B_PCE  = 3;
  localparam int B_EDE  = 4;
  localparam int B_TOE  = 5;
  localparam int B_GIE  = 7;
  // Option fields.
  localparam int B_EDGE = 6;
  localparam int B_PSA  = 3;
  localparam int B_PS_LSB = 0;
  // Status and configuration fields.
  localparam int B_PD_N = 3;
  localparam int B_TO_N = 4;
  localparam int B_WATCHDOG_ENABLE_CFG = 3;
  // Reset values and interrupt vector.
  localparam logic [7:0] RST_IRQCTL = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_TIMER  = 8'h00;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  // Watchdog timing on its own RC oscillator.
  localparam int WDT_TIMEOUT_US    = 18000;
  localparam int WDT_OSC_PERIOD_US = 1;
  localparam int WDT_BASE_TICKS    = WDT_TIMEOUT_US / WDT_OSC_PERIOD_US;
  localparam int WDT_CNT_W         = 15;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP} wsc_mode_t;
endpackage : wsc_pkg

// >>> verif/wsc_core_bench.sv
// Self-checking bench for the watchdog, interrupt flag and power-down block.
// Assumes wsc_core alone on one 100 MHz clock; the bench drives every port itself.
module wsc_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // A short watchdog base keeps each timeout at a few oscillator ticks: 4 without prescaler, 8 at 1:2.
  localparam int WB = 4;
  logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, wdt_osc = 1'b0, ext_pin = 1'b0;
  logic        tmr_tick = 1'b0, irq_ack = 1'b0;
  logic [2:0]  ins = 3'b000;
  logic [13:0] addr = 14'h0000;
  logic [7:0]  wdata = 8'h00, cfg = 8'h08, rdata;
  logic [3:0]  port_pin = 4'h0;
  logic [12:0] ret_pc = 13'h0000, push_pc, vec_pc;
  logic        irq_req, push_stb, vec_load, wake, wake_vec, wdt_reset, sleeping, osc_drv_en, io_hold;
  int          n_fail = 0, cmp_count = 0, r, w;
  always #5 clk = ~clk;
  wsc_core #(.WDT_BASE(WB)) dut_u (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .CFG_WORD(cfg), .WDT_OSC(wdt_osc), .EXT_IRQ_PIN(ext_pin),
    .PORT_PIN(port_pin), .TMR_TICK(tmr_tick), .CLR_WDT_INSTR(ins[0]), .SLEEP_INSTR(ins[1]),
    .RETFIE_INSTR(ins[2]), .IRQ_ACK(irq_ack), .RET_PC(ret_pc), .IRQ_REQ(irq_req), .PUSH_STB(push_stb),
    .PUSH_PC(push_pc), .VEC_LOAD(vec_load), .VEC_PC(vec_pc), .WAKE(wake), .WAKE_VECTOR(wake_vec),
    .WDT_RESET(wdt_reset), .SLEEPING(sleeping), .OSC_DRV_EN(osc_drv_en), .IO_HOLD(io_hold));
  task chk(input logic [12:0] got, input logic [12:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task do_reset(input logic [7:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg <= c;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task wreg(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wreg
  task rchk(input logic [13:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk({5'h00, rdata}, {5'h00, e}, m);
  endtask : rchk
  task instr(input logic [2:0] v);
    @(posedge clk);
    ins <= v;
    @(posedge clk);
    ins <= 3'b000;
  endtask : instr
  // Each oscillator tick spans ten main cycles so the synchroniser lag stays inside one tick.
  task wticks(input int n, output int at_r, output int at_w);
    at_r = 0;
    at_w = 0;
    for (int i = 1; i <= n; i++)
      for (int c = 0; c < 10; c++)
      begin
        @(posedge clk);
        wdt_osc <= (c < 5);
        #1;
        if (wdt_reset === 1'b1 && at_r == 0) at_r = i;
        if (wake === 1'b1 && at_w == 0) at_w = i;
      end
  endtask : wticks
  task t_reset;
    rchk(wsc_pkg::ADR_OPTION, 8'hFF, "option reset");
    rchk(wsc_pkg::ADR_IRQCTL, 8'h00, "irq control reset");
    rchk(wsc_pkg::ADR_STATUS, 8'h18, "status reset");
    rchk(14'h0050, 8'h00, "unmapped read");
    chk(vec_pc, 13'h0004, "vector");
    chk({11'h000, osc_drv_en, io_hold}, 13'h0002, "run drive state");
    $display("test reset done");
  endtask : t_reset
  task t_timer;
    @(posedge clk);
    tmr_tick <= 1'b1;
    repeat (255) @(posedge clk);
    tmr_tick <= 1'b0;
    rchk(wsc_pkg::ADR_IRQCTL, 8'h00, "no flag at FFh");
    @(posedge clk);
    tmr_tick <= 1'b1;
    @(posedge clk);
    tmr_tick <= 1'b0;
    rchk(wsc_pkg::ADR_IRQCTL, 8'h04, "overflow flag");
    chk(irq_req, 1'b0, "request without enables");
    wreg(wsc_pkg::ADR_IRQCTL, 8'hA4);
    #1 chk(irq_req, 1'b1, "request enabled");
    ret_pc <= 13'h1ABC;
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
    #1 chk({push_stb, vec_load, irq_req}, 13'h0006, "accept pulses");
    chk(push_pc, 13'h1ABC, "pushed pc");
    rchk(wsc_pkg::ADR_IRQCTL, 8'h24, "global enable cleared");
    instr(3'b100);
    rchk(wsc_pkg::ADR_IRQCTL, 8'hA4, "return re-enables");
    wreg(wsc_pkg::ADR_IRQCTL, 8'h00);
    rchk(wsc_pkg::ADR_IRQCTL, 8'h00, "software clear");
    $display("test timer done");
  endtask : t_timer
  task t_pins;
    int b[3] = '{0, 1, 3};
    @(posedge clk);
    ext_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rchk(wsc_pkg::ADR_IRQCTL, 8'h02, "rising edge");
    wreg(wsc_pkg::ADR_OPTION, 8'hBF);
    wreg(wsc_pkg::ADR_IRQCTL, 8'h00);
    ext_pin <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(wsc_pkg::ADR_IRQCTL, 8'h02, "falling edge");
    wreg(wsc_pkg::ADR_IRQCTL, 8'h00);
    ext_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rchk(wsc_pkg::ADR_IRQCTL, 8'h00, "unselected edge");
    wreg(wsc_pkg::ADR_OPTION, 8'hFF);
    port_pin <= 4'h4;
    repeat (8) @(posedge clk);
    rchk(wsc_pkg::ADR_IRQCTL, 8'h00, "unwatched pin");
    foreach (b[i])
    begin
      wreg(wsc_pkg::ADR_IRQCTL, 8'h00);
      port_pin <= port_pin ^ (4'h1 << b[i]);
      repeat (8) @(posedge clk);
      rchk(wsc_pkg::ADR_IRQCTL, 8'h01, "port change");
    end
    wreg(wsc_pkg::ADR_IRQCTL, 8'h89);
    #1 chk(irq_req, 1'b1, "port change request");
    wreg(wsc_pkg::ADR_IRQCTL, 8'h81);
    #1 chk(irq_req, 1'b0, "port change masked");
    wreg(wsc_pkg::ADR_IRQCTL, 8'h00);
    $display("test pins done");
  endtask : t_pins
  task t_sleep_edge;
    int k;
    for (int g = 0; g < 2; g++)
    begin
      ext_pin <= 1'b0;
      repeat (8) @(posedge clk);
      wreg(wsc_pkg::ADR_IRQCTL, {g[0], 7'h10});
      instr(3'b010);
      #1 chk({sleeping, osc_drv_en, io_hold}, 13'h0005, "asleep");
      rchk(wsc_pkg::ADR_STATUS, 8'h10, "sleep status");
      ext_pin <= 1'b1;
      k = 0;
      while (wake !== 1'b1 && k < 20)
      begin
        @(posedge clk);
        #1 k++;
      end
      chk({wake, wake_vec}, {11'h000, 1'b1, g[0]}, "edge wake");
      wreg(wsc_pkg::ADR_IRQCTL, 8'h00);
    end
    $display("test sleep edge done");
  endtask : t_sleep_edge
  task t_wdt;
    wreg(wsc_pkg::ADR_OPTION, 8'hF0);
    instr(3'b001);
    wticks(6, r, w);
    chk(r[12:0], WB, "timeout unscaled");
    rchk(wsc_pkg::ADR_STATUS, 8'h08, "timeout status");
    instr(3'b001);
    wreg(wsc_pkg::ADR_OPTION, 8'hF9);
    rchk(wsc_pkg::ADR_STATUS, 8'h18, "clear sets status");
    wticks(5, r, w);
    instr(3'b001);
    wticks(10, r, w);
    chk(r[12:0], 2 * WB, "timeout scaled after clear");
    instr(3'b010);
    wticks(10, r, w);
    chk(r[12:0], 13'h0000, "no reset asleep");
    chk(w[12:0], 2 * WB, "watchdog wake");
    rchk(wsc_pkg::ADR_STATUS, 8'h00, "wake status");
    $display("test watchdog done");
  endtask : t_wdt
  task t_wdt_off;
    do_reset(8'h00);
    wreg(wsc_pkg::ADR_OPTION, 8'hF0);
    wticks(8, r, w);
    chk(r[12:0], 13'h0000, "watchdog disabled");
    $display("test watchdog off done");
  endtask : t_wdt_off
  initial
  begin
    do_reset(8'h08);
    t_reset;
    t_timer;
    t_pins;
    t_sleep_edge;
    t_wdt;
    t_wdt_off;
    test_done;
  end
  // The whole sequence needs under 5000 cycles, so 20000 cycles means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done;
  end
endmodule : wsc_core_bench
